/* flash_sec_cfg.svh */
`ifndef FLASH_SEC_CFG_SVH
`define FLASH_SEC_CFG_SVH

// opcodes
`define OP_ID_PAIR_READ 8'h90
`define OP_ID_PAIR_READ_ALT 8'hdf
`define OP_ID_PAIR_READ_QUAD 8'hef
`define OP_SEC_REG_READ 8'h28
`define OP_FAIL_FLAGS_CLEAR 8'h30
`define OP_OTP_REGION_ENTER 8'hb1
`define OP_OTP_REGION_EXIT 8'hc1
`define OP_SEC_REG_WRITE 8'h2f
`define OP_PROTECT_MODE_SELECT 8'h68
`define OP_WIDE_ADDRESS_ENTER 8'hb7
`define OP_WIDE_ADDRESS_EXIT 8'he9
`define OP_STATUS_REG_WRITE 8'h01
`define OP_SINGLE_BLOCK_LOCK 8'h36
`define OP_SINGLE_BLOCK_UNLOCK 8'h39
`define OP_WHOLE_CHIP_LOCK 8'h7e
`define OP_WHOLE_CHIP_UNLOCK 8'h98
`define OP_BLOCK_ERASE 8'hd8
`define OP_SECTOR_ERASE 8'h20
`define OP_HALF_BLOCK_ERASE 8'h52
`define OP_CHIP_ERASE 8'hc7
`define OP_CHIP_ERASE_ALT 8'h60

// identity bytes, values arbitrary
`define ID_MAKER 8'h5a
`define ID_DEVICE 8'h3c

// id address that swaps byte order
`define ID_SWAP_ADDR 8'h01

// security register fields
`define SEC_PROT_MODE 7
`define SEC_ERASE_FAIL 6
`define SEC_PROG_FAIL 5
`define SEC_CONT_PROG 4
`define SEC_RESERVED 3
`define SEC_WIDE_ADDR 2
`define SEC_OTP_LOCK 1
`define SEC_FACTORY_LOCK 0

// id read header after the opcode: two dummy plus address byte
`define ID_HEADER_BYTES 3'h3

// synchroniser levels during reset: wp, si, sclk, cs
`define PIN_IDLE_LEVELS 4'h9

`endif

/* flash_sec_pkg.sv */
package flash_sec_pkg;
   typedef enum logic [2:0] {
      ST_OPCODE,
      ST_ID_HEADER,
      ST_ID_OUT,
      ST_SEC_OUT,
      ST_SEC_WRITE,
      ST_IGNORE
   } cmd_state_t;
endpackage

/* flash_sec_id.sv */
// Behaviour
// - id read: opcode, two dummies, address
// - id bytes out on falling edge, msb first
// - address 01h gives device id first
// - id bytes alternate until select rises
// - otp entry redirects reads and programs
// - otp mode rejects writes, locks, erases
// - otp exit restores main array addressing
// - security read anytime, repeats byte
// - security register bit layout
// - bit0 read-only factory lock indicator
// - otp lock settable once, then frozen
// - no main array access in otp mode
// - wide address bit set/clear by commands
// - continuous program bit mirrors mode
// - program fail sticky until clear command
// - erase fail sticky until clear command
// - protection select one-way set
// - select chooses one protection scheme
// - per-block mode powers up all locked
// - write-protect low protects whole array only when prot_mode_stored is set
// - security write needs byte-aligned select rise
// - security read opcode 28h, allowed in cp
`timescale 1ns/1ps
`include "flash_sec_cfg.svh"

module flash_sec_id (
   input wire logic clock,
   input wire logic rst,
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic si,
   output logic so,
   output logic so_oe,
   input wire logic wp_n,
   input wire logic factory_lock,
   input wire logic prot_mode_stored,
   input wire logic otp_lock_stored,
   input wire logic cont_prog_active,
   input wire logic busy,
   input wire logic prog_fail_event,
   input wire logic erase_fail_event,
   input wire logic block_locked,
   output logic prot_mode_program,
   output logic otp_lock_program,
   output logic otp_mode,
   output logic wide_address,
   output logic otp_write_allowed,
   output logic array_write_protected,
   output logic bp_scheme_active,
   output logic cmd_reject,
   output logic [7:0] sec_value
);
   import flash_sec_pkg::*;

   // ---------------------------------
   // pin synchronisers
   // ---------------------------------
   logic sclk_last_reg;
   wire [3:0] pin_sync;
   wire [3:0] pin_raw = {wp_n, si, sclk, cs_n};
   localparam logic [3:0] pin_idle = `PIN_IDLE_LEVELS;
   genvar pin;

   for (pin = 0; pin < 4; pin = pin + 1) begin : g_sync
      logic meta_reg;
      logic sync_reg;
      always_ff @(posedge clock or posedge rst) begin
         if (rst) begin
            meta_reg <= pin_idle[pin];
            sync_reg <= pin_idle[pin];
         end else begin
            meta_reg <= pin_raw[pin];
            sync_reg <= meta_reg;
         end
      end
      assign pin_sync[pin] = sync_reg;
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         sclk_last_reg <= 1'b0;
      end else begin
         sclk_last_reg <= pin_sync[1];
      end
   end

   wire cs_low = ~pin_sync[0];
   wire sclk_rise = cs_low & pin_sync[1] & ~sclk_last_reg;
   wire sclk_fall = cs_low & ~pin_sync[1] & sclk_last_reg;
   wire si_bit = pin_sync[2];
   wire wp_low = ~pin_sync[3];

   // ---------------------------------
   // bit and byte shifter
   // ---------------------------------
   logic [2:0] bit_cnt_reg;
   logic [6:0] shift_reg;
   logic cs_low_last_reg;
   wire [7:0] rx_byte = {shift_reg, si_bit};
   wire byte_done = sclk_rise & (bit_cnt_reg == 3'h7);
   wire cs_rise = cs_low_last_reg & ~cs_low;
   wire on_boundary = (bit_cnt_reg == 3'h0);

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         bit_cnt_reg <= 3'h0;
         shift_reg <= 7'h00;
         cs_low_last_reg <= 1'b0;
      end else begin
         cs_low_last_reg <= cs_low;
         if (!cs_low) begin
            bit_cnt_reg <= 3'h0;
         end else if (sclk_rise) begin
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            shift_reg <= rx_byte[6:0];
         end
      end
   end

   // ---------------------------------
   // opcode decode
   // ---------------------------------
   wire op_id = (rx_byte == `OP_ID_PAIR_READ) | (rx_byte == `OP_ID_PAIR_READ_ALT) |
                (rx_byte == `OP_ID_PAIR_READ_QUAD);
   wire op_sec_read = (rx_byte == `OP_SEC_REG_READ);
   wire op_sec_write = (rx_byte == `OP_SEC_REG_WRITE);
   wire op_otp_enter = (rx_byte == `OP_OTP_REGION_ENTER);
   wire op_otp_exit = (rx_byte == `OP_OTP_REGION_EXIT);
   wire op_clear = (rx_byte == `OP_FAIL_FLAGS_CLEAR);
   wire op_prot_sel = (rx_byte == `OP_PROTECT_MODE_SELECT);
   wire op_wide_en = (rx_byte == `OP_WIDE_ADDRESS_ENTER);
   wire op_wide_ex = (rx_byte == `OP_WIDE_ADDRESS_EXIT);
   wire op_status_write = (rx_byte == `OP_STATUS_REG_WRITE);
   wire op_block_lock = (rx_byte == `OP_SINGLE_BLOCK_LOCK);
   wire op_block_unlock = (rx_byte == `OP_SINGLE_BLOCK_UNLOCK);
   wire op_chip_lock = (rx_byte == `OP_WHOLE_CHIP_LOCK);
   wire op_chip_unlock = (rx_byte == `OP_WHOLE_CHIP_UNLOCK);
   wire op_block_erase = (rx_byte == `OP_BLOCK_ERASE) | (rx_byte == `OP_HALF_BLOCK_ERASE);
   wire op_sector_erase = (rx_byte == `OP_SECTOR_ERASE);
   wire op_chip_erase = (rx_byte == `OP_CHIP_ERASE) | (rx_byte == `OP_CHIP_ERASE_ALT);
   wire op_guarded = op_status_write | op_sec_write | op_prot_sel | op_block_lock | op_block_unlock |
                     op_chip_lock | op_chip_unlock | op_block_erase | op_sector_erase | op_chip_erase;

   // ---------------------------------
   // command state machine
   // ---------------------------------
   cmd_state_t state_reg;
   cmd_state_t state_next;
   logic [1:0] hdr_cnt_reg;
   logic swap_reg;
   logic [7:0] pend_reg;
   logic pend_valid_reg;
   logic reject_reg;
   logic otp_mode_reg;
   logic wide_reg;
   logic prog_fail_reg;
   logic erase_fail_reg;
   logic prot_prog_reg;
   logic otp_lock_prog_reg;

   wire opcode_byte = byte_done & (state_reg == ST_OPCODE);
   wire reject_now = opcode_byte & otp_mode_reg & op_guarded;
   wire accept = opcode_byte & ~reject_now & (~cont_prog_active | op_sec_read);
   wire pend_done = cs_rise & pend_valid_reg & on_boundary;
   wire header_last = byte_done & (state_reg == ST_ID_HEADER) & (hdr_cnt_reg == 2'h2);

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_OPCODE: begin
            if (opcode_byte) begin
               if (accept & op_id & ~busy) begin
                  state_next = ST_ID_HEADER;
               end else if (accept & op_sec_read) begin
                  state_next = ST_SEC_OUT;
               end else begin
                  state_next = ST_IGNORE;
               end
            end
         end
         ST_ID_HEADER: begin
            if (header_last) begin
               state_next = ST_ID_OUT;
            end
         end
         ST_ID_OUT: state_next = ST_ID_OUT;
         ST_SEC_OUT: state_next = ST_SEC_OUT;
         ST_SEC_WRITE: state_next = ST_SEC_WRITE;
         ST_IGNORE: state_next = ST_IGNORE;
         default: state_next = ST_OPCODE;
      endcase
      if (!cs_low) begin
         state_next = ST_OPCODE;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state_reg <= ST_OPCODE;
      end else begin
         state_reg <= state_next;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         hdr_cnt_reg <= 2'h0;
         swap_reg <= 1'b0;
      end else begin
         if (state_reg != ST_ID_HEADER) begin
            hdr_cnt_reg <= 2'h0;
         end else if (byte_done) begin
            hdr_cnt_reg <= hdr_cnt_reg + 2'h1;
         end
         if (header_last) begin
            swap_reg <= (rx_byte == `ID_SWAP_ADDR);
         end
      end
   end

   // ---------------------------------
   // commands executed at select rise
   // ---------------------------------
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         pend_reg <= 8'h00;
         pend_valid_reg <= 1'b0;
         reject_reg <= 1'b0;
      end else begin
         reject_reg <= reject_now;
         if (accept & ~busy) begin
            pend_reg <= rx_byte;
            pend_valid_reg <= 1'b1;
         end else if (!cs_low || (sclk_rise && state_reg != ST_OPCODE)) begin
            pend_valid_reg <= 1'b0;
         end
      end
   end

   wire run_otp_enter = pend_done & (pend_reg == `OP_OTP_REGION_ENTER);
   wire run_otp_exit = pend_done & (pend_reg == `OP_OTP_REGION_EXIT);
   wire run_sec_write = pend_done & (pend_reg == `OP_SEC_REG_WRITE) & ~otp_lock_stored;
   wire run_prot_sel = pend_done & (pend_reg == `OP_PROTECT_MODE_SELECT);
   wire run_wide_en = pend_done & (pend_reg == `OP_WIDE_ADDRESS_ENTER);
   wire run_wide_ex = pend_done & (pend_reg == `OP_WIDE_ADDRESS_EXIT);
   wire run_clear = pend_done & (pend_reg == `OP_FAIL_FLAGS_CLEAR);

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         otp_mode_reg <= 1'b0;
         wide_reg <= 1'b0;
      end else begin
         if (run_otp_enter) begin
            otp_mode_reg <= 1'b1;
         end else if (run_otp_exit) begin
            otp_mode_reg <= 1'b0;
         end
         if (run_wide_en) begin
            wide_reg <= 1'b1;
         end else if (run_wide_ex) begin
            wide_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         prog_fail_reg <= 1'b0;
         erase_fail_reg <= 1'b0;
      end else begin
         prog_fail_reg <= prog_fail_event | (prog_fail_reg & ~run_clear);
         erase_fail_reg <= erase_fail_event | (erase_fail_reg & ~run_clear);
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         prot_prog_reg <= 1'b0;
         otp_lock_prog_reg <= 1'b0;
      end else begin
         prot_prog_reg <= run_prot_sel & ~prot_mode_stored;
         otp_lock_prog_reg <= run_sec_write;
      end
   end

   // ---------------------------------
   // security register and protection
   // ---------------------------------
   wire [7:0] sec_bits;
   assign sec_bits[`SEC_PROT_MODE] = prot_mode_stored;
   assign sec_bits[`SEC_ERASE_FAIL] = erase_fail_reg;
   assign sec_bits[`SEC_PROG_FAIL] = prog_fail_reg;
   assign sec_bits[`SEC_CONT_PROG] = cont_prog_active;
   assign sec_bits[`SEC_RESERVED] = 1'b0;
   assign sec_bits[`SEC_WIDE_ADDR] = wide_reg;
   assign sec_bits[`SEC_OTP_LOCK] = otp_lock_stored;
   assign sec_bits[`SEC_FACTORY_LOCK] = factory_lock;
   assign sec_value = sec_bits;
   assign prot_mode_program = prot_prog_reg;
   assign otp_lock_program = otp_lock_prog_reg;
   assign otp_mode = otp_mode_reg;
   assign wide_address = wide_reg;
   assign otp_write_allowed = otp_mode_reg & ~otp_lock_stored & ~factory_lock;
   assign bp_scheme_active = ~prot_mode_stored;
   assign array_write_protected = otp_mode_reg |
                                  (prot_mode_stored & (wp_low | block_locked));
   assign cmd_reject = reject_reg;

   // ---------------------------------
   // serial output on falling edge
   // ---------------------------------
   logic [7:0] out_shift_reg;
   logic id_sel_reg;
   logic so_reg;
   wire swap_sel = header_last ? (rx_byte == `ID_SWAP_ADDR) : swap_reg;
   wire [7:0] id_first = swap_sel ? `ID_DEVICE : `ID_MAKER;
   wire [7:0] id_second = swap_sel ? `ID_MAKER : `ID_DEVICE;
   wire out_active = (state_reg == ST_ID_OUT) | (state_reg == ST_SEC_OUT);

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         out_shift_reg <= 8'h00;
         id_sel_reg <= 1'b0;
         so_reg <= 1'b0;
      end else if (!out_active) begin
         id_sel_reg <= 1'b0;
         out_shift_reg <= (state_next == ST_SEC_OUT) ? sec_value : id_first;
      end else if (sclk_fall) begin
         so_reg <= out_shift_reg[7];
         if (bit_cnt_reg == 3'h0) begin
            out_shift_reg <= {out_shift_reg[6:0], 1'b0};
         end else begin
            out_shift_reg <= {out_shift_reg[6:0], 1'b0};
         end
      end else if (byte_done) begin
         id_sel_reg <= ~id_sel_reg;
         if (state_reg == ST_SEC_OUT) begin
            out_shift_reg <= sec_value;
         end else begin
            out_shift_reg <= id_sel_reg ? id_first : id_second;
         end
      end
   end

   assign so = so_reg;
   assign so_oe = out_active & cs_low;
endmodule

/* flash_sec_id_asserts.sv */
`timescale 1ns/1ps
// ---------------
// port checks
// ---------------
module flash_sec_id_asserts (
   input wire logic clock,
   input wire logic rst,
   input wire logic cs_n,
   input wire logic so_oe,
   input wire logic wp_n,
   input wire logic factory_lock,
   input wire logic prot_mode_stored,
   input wire logic cont_prog_active,
   input wire logic prog_fail_event,
   input wire logic erase_fail_event,
   input wire logic otp_mode,
   input wire logic wide_address,
   input wire logic otp_write_allowed,
   input wire logic array_write_protected,
   input wire logic bp_scheme_active,
   input wire logic cmd_reject,
   input wire logic [7:0] sec_value
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   sequence cs_idle;
      cs_n [*5];
   endsequence
   sequence pins_still;
      $stable({factory_lock, prot_mode_stored, cont_prog_active}) [*3];
   endsequence
   chk_oe_idle: assert property (cs_idle |-> !so_oe)
      else $error("so driven while deselected");
   chk_nv_bits: assert property (pins_still |-> sec_value[0] == factory_lock &&
      sec_value[7] == prot_mode_stored && sec_value[4] == cont_prog_active) else $error("status bits wrong");
   chk_wide_bit: assert property (sec_value[2] == wide_address)
      else $error("wide bit wrong");
   chk_pfail_set: assert property (prog_fail_event |-> ##[1:2] sec_value[5])
      else $error("program fail not set");
   chk_efail_set: assert property (erase_fail_event |-> ##[1:2] sec_value[6])
      else $error("erase fail not set");
   chk_fail_sticky: assert property ($fell(sec_value[5]) || $fell(sec_value[6]) |-> cs_n)
      else $error("fail flag dropped in frame");
   chk_otp_only: assert property (cmd_reject || otp_write_allowed |-> otp_mode)
      else $error("otp output outside otp mode");
   chk_mode_quiet: assert property ($changed(otp_mode) || $changed(wide_address) |-> cs_n)
      else $error("mode changed in frame");
   chk_wp_all: assert property ((prot_mode_stored && !wp_n) [*4] |-> array_write_protected)
      else $error("array open with wp low");
   chk_one_scheme: assert property ($stable(prot_mode_stored) [*3] |-> bp_scheme_active != prot_mode_stored)
      else $error("scheme select wrong");
endmodule

bind flash_sec_id flash_sec_id_asserts u_chk (.clock, .rst, .cs_n, .so_oe, .wp_n, .factory_lock,
   .prot_mode_stored, .cont_prog_active, .prog_fail_event, .erase_fail_event, .otp_mode, .wide_address,
   .otp_write_allowed, .array_write_protected, .bp_scheme_active, .cmd_reject, .sec_value);

/* spi_host_model.sv */
`timescale 1ns/1ps
// ---------------
// serial host
// ---------------
module spi_host_model (
   output logic cs_n,
   output logic sclk,
   output logic si,
   input wire logic so
);
   localparam real half = 62.5;
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      si = 1'b0;
   end
   // nbits of tx msb first, then nread bits in
   task automatic frame(input logic [31:0] tx, input int nbits, input int nread, output logic [31:0] rx);
      rx = 32'h0;
      #1 cs_n = 1'b0;
      for (int i = 0; i < nbits; i++) begin
         si = tx[31 - i];
         #(half) sclk = 1'b1;
         #(half) sclk = 1'b0;
      end
      for (int i = 0; i < nread; i++) begin
         si = ~si;
         #(half) sclk = 1'b1;
         rx = {rx[30:0], so};
         #(half) sclk = 1'b0;
      end
      #(half) cs_n = 1'b1;
      si = ~si;
      #(2 * half);
   endtask
endmodule

/* flash_sec_id_test.sv */
`timescale 1ns/1ps
`include "flash_sec_cfg.svh"
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_fail++; \
   $display("wrong value at %0t: got %h expected %h", $time, a, e); end end
module flash_sec_id_test;
   logic clock, rst, wp_n, factory_lock, prot_mode_stored, otp_lock_stored, cont_prog_active, busy;
   logic prog_fail_event, erase_fail_event, block_locked;
   wire logic cs_n, sclk, si, so, so_oe, prot_mode_program, otp_lock_program, otp_mode, wide_address;
   wire logic otp_write_allowed, array_write_protected, bp_scheme_active, cmd_reject;
   wire logic [7:0] sec_value;
   logic [31:0] rx;
   int n_fail, checks, n_rej, n_lock, n_sel;
   flash_sec_id dut (.clock, .rst, .cs_n, .sclk, .si, .so, .so_oe, .wp_n, .factory_lock, .prot_mode_stored,
      .otp_lock_stored, .cont_prog_active, .busy, .prog_fail_event, .erase_fail_event, .block_locked,
      .prot_mode_program, .otp_lock_program, .otp_mode, .wide_address, .otp_write_allowed,
      .array_write_protected, .bp_scheme_active, .cmd_reject, .sec_value);
   spi_host_model host (.cs_n, .sclk, .si, .so);
   // ---------------
   // helpers
   // ---------------
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   always @(posedge clock) begin
      if (cmd_reject === 1'b1) n_rej++;
      if (otp_lock_program === 1'b1) n_lock++;
      if (prot_mode_program === 1'b1) n_sel++;
   end
   task automatic end_sim();
      if (n_fail == 0 && checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic xfer(input logic [31:0] tx, input int nbits, input int nread);
      @(negedge clock);
      host.frame(tx, nbits, nread, rx);
   endtask
   task automatic cmd(input logic [7:0] op);
      xfer({op, 24'h0}, 8, 0);
   endtask
   task automatic settle();
      repeat (6) @(negedge clock);
   endtask
   // ---------------
   // scenarios
   // ---------------
   task automatic t_id();
      logic [7:0] ops [3] = '{8'h90, 8'hdf, 8'hef};
      logic [7:0] a, b;
      foreach (ops[i]) for (int s = 0; s < 2; s++) begin
         a = s ? `ID_DEVICE : `ID_MAKER;
         b = s ? `ID_MAKER : `ID_DEVICE;
         xfer({ops[i], 16'h0, 7'h0, s[0]}, 32, 32);
         `CHK(rx, {a, b, a, b})
         `CHK(so_oe, 1'b0)
      end
   endtask
   task automatic t_sec();
      @(negedge clock);
      {factory_lock, cont_prog_active, busy, prot_mode_stored} = 4'hf;
      settle();
      xfer({`OP_SEC_REG_READ, 24'h0}, 8, 16);
      `CHK(rx[15:0], 16'h9191)
      cmd(`OP_WIDE_ADDRESS_ENTER);
      `CHK(wide_address, 1'b0)
      @(negedge clock);
      {factory_lock, cont_prog_active, busy, prot_mode_stored} = 4'h0;
   endtask
   task automatic t_fail();
      @(negedge clock) prog_fail_event = 1'b1;
      @(negedge clock) prog_fail_event = 1'b0;
      erase_fail_event = 1'b1;
      @(negedge clock) erase_fail_event = 1'b0;
      cmd(8'ha5);
      `CHK(sec_value, 8'h60)
      xfer({`OP_FAIL_FLAGS_CLEAR, 24'h0}, 9, 0);
      `CHK(sec_value[6:5], 2'b11)
      cmd(`OP_FAIL_FLAGS_CLEAR);
      `CHK(sec_value[6:5], 2'b00)
   endtask
   task automatic t_wide();
      cmd(`OP_WIDE_ADDRESS_ENTER);
      `CHK({wide_address, sec_value[2]}, 2'b11)
      cmd(`OP_WIDE_ADDRESS_EXIT);
      `CHK({wide_address, sec_value[2]}, 2'b00)
   endtask
   task automatic t_otp();
      logic [7:0] g [12] = '{8'h01, 8'h2f, 8'h68, 8'h36, 8'h39, 8'h7e, 8'h98, 8'hd8, 8'h20, 8'h52, 8'hc7, 8'h60};
      int r, s;
      cmd(`OP_OTP_REGION_ENTER);
      `CHK({otp_mode, otp_write_allowed}, 2'b11)
      `CHK(array_write_protected, 1'b1)
      r = n_rej;
      s = n_lock + n_sel;
      foreach (g[i]) cmd(g[i]);
      `CHK(n_rej - r, 12)
      `CHK(n_lock + n_sel - s, 0)
      cmd(`OP_OTP_REGION_EXIT);
      `CHK(otp_mode, 1'b0)
   endtask
   task automatic t_wsec();
      int l;
      l = n_lock;
      xfer({`OP_SEC_REG_WRITE, 24'h0}, 9, 0);
      `CHK(n_lock - l, 0)
      cmd(`OP_SEC_REG_WRITE);
      `CHK(n_lock - l, 1)
      @(negedge clock);
      otp_lock_stored = 1'b1;
      cmd(`OP_SEC_REG_WRITE);
      `CHK(n_lock - l, 1)
      cmd(`OP_OTP_REGION_ENTER);
      `CHK({otp_mode, otp_write_allowed}, 2'b10)
      cmd(`OP_OTP_REGION_EXIT);
      l = n_sel;
      cmd(`OP_PROTECT_MODE_SELECT);
      `CHK(n_sel - l, 1)
   endtask
   task automatic t_prot();
      int l;
      `CHK(bp_scheme_active, 1'b1)
      @(negedge clock);
      {prot_mode_stored, block_locked} = 2'b11;
      settle();
      `CHK({bp_scheme_active, array_write_protected}, 2'b01)
      l = n_sel;
      cmd(`OP_PROTECT_MODE_SELECT);
      `CHK(n_sel - l, 0)
      block_locked = 1'b0;
      settle();
      `CHK(array_write_protected, 1'b0)
      wp_n = 1'b0;
      settle();
      `CHK(array_write_protected, 1'b1)
   endtask
   initial begin
      #400000;
      n_fail++;
      end_sim();
   end
   initial begin
      rst = 1'b1;
      {wp_n, factory_lock, prot_mode_stored, otp_lock_stored} = 4'h8;
      {cont_prog_active, busy, prog_fail_event, erase_fail_event, block_locked} = 5'h0;
      repeat (4) @(negedge clock);
      rst = 1'b0;
      settle();
      `CHK(sec_value, 8'h00)
      t_id();
      t_sec();
      t_fail();
      t_wide();
      t_otp();
      t_wsec();
      t_prot();
      end_sim();
   end
endmodule
